// ### logic/hpb_bridge.sv
// packet interpreter driving two-wire, spi and pin port
`timescale 1ns/10ps
module hpb_bridge
    import hpb_pkg::*;
#(
    parameter int MAX_PKT = HPB_MAX_PKT
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic pktValid,
    input wire logic [7:0] pktByte,
    input wire logic pktLast,
    output logic pktReady,
    output logic rspValid,
    output logic [7:0] rspByte,
    output logic rspLast,
    input wire logic rspReady,
    output logic sclOe,
    input wire logic sclIn,
    output logic sdaOe,
    input wire logic sdaIn,
    output logic spiClk,
    output logic spiMosi,
    input wire logic spiMiso,
    output logic spiCsN,
    output logic [6:0] pinOut,
    input wire logic [6:0] pinIn,
    output logic busy
);
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        S_RX = 7'b000_0001,
        S_DEC = 7'b000_0010,
        S_SPI = 7'b000_0100,
        S_TW = 7'b000_1000,
        S_PIN = 7'b001_0000,
        S_TX = 7'b010_0000,
        S_IDLE = 7'b100_0000
    } hpb_state_t;

    typedef enum logic [3:0] {
        T_START = 4'h1,
        T_BIT = 4'h2,
        T_ACK = 4'h4,
        T_STOP = 4'h8
    } hpb_twph_t;

    function automatic logic validHdr(input logic [7:0] b);
        logic [7:0] ifc;
        ifc = b & 8'h0F;
        validHdr = ((b & 8'hE0) == 8'h00) && (ifc == HPB_IF_PIN || ifc == HPB_IF_SPI16
            || ifc == HPB_IF_FAST || ifc == HPB_IF_STD || ifc == HPB_IF_SPI8);
    endfunction

    logic [7:0] buf_reg [0:MAX_PKT-1];
    hpb_state_t state_reg;
    logic [5:0] rxCnt_reg;
    logic [5:0] idx_reg;
    logic [5:0] endIdx_reg;
    logic [7:0] status_reg;
    logic isWrite;
    logic [7:0] ifCode;
    logic [7:0] lenB;
    logic [11:0] divPeriod;
    logic tick;
    logic shLoad;
    logic [7:0] shByte;
    logic shEn;
    logic shOut;
    logic [7:0] shCap;
    logic [1:0] q_reg;
    logic [3:0] bit_reg;
    hpb_twph_t tw_reg;
    logic [1:0] twSeg_reg;
    logic restarted_reg;
    logic twRead;
    logic rxTake;
    logic rxEnd;
    logic [5:0] rspIdx;

    assign isWrite = (buf_reg[0] & HPB_OP_WRITE) != 8'h00;
    assign ifCode = buf_reg[0] & 8'h0F;
    assign lenB = buf_reg[2];
    assign twRead = !isWrite && restarted_reg;
    assign rxTake = pktValid && pktReady && (state_reg == S_IDLE || state_reg == S_RX);
    assign rxEnd = rxTake && (pktLast || rxCnt_reg == 6'(MAX_PKT - 1));
    assign rspIdx = rspValid ? idx_reg + 6'd1 : 6'd0;

    // ------------------------------------------------------------
    // bit-rate dividers
    // ------------------------------------------------------------
    always_comb begin
        if (ifCode == HPB_IF_STD) begin
            divPeriod = 12'(HPB_STD_Q);
        end else if (ifCode == HPB_IF_FAST) begin
            divPeriod = 12'(HPB_FAST_Q);
        end else begin
            divPeriod = 12'(HPB_SPI_H);
        end
    end

    hpb_tick #(.W(12)) uTick (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .run(state_reg == S_SPI || state_reg == S_TW),
        .period(divPeriod),
        .tick(tick)
    );

    hpb_shift uShift (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .load(shLoad),
        .loadByte(shByte),
        .shiftEn(shEn),
        .inBit(state_reg == S_SPI ? spiMiso : sdaIn),
        .outBit(shOut),
        .capByte(shCap)
    );

    // ------------------------------------------------------------
    // packet receive and response
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxCnt_reg <= 6'd0;
            pktReady <= 1'b0;
            rspValid <= 1'b0;
            rspByte <= 8'h00;
            rspLast <= 1'b0;
            busy <= 1'b0;
        end else begin
            pktReady <= (state_reg == S_IDLE || state_reg == S_RX) && !rxEnd;
            busy <= (state_reg != S_IDLE) && (state_reg != S_RX);
            if (rxTake) begin
                rxCnt_reg <= rxCnt_reg + 6'd1;
            end else if (state_reg == S_IDLE) begin
                rxCnt_reg <= 6'd0;
            end
            if (state_reg == S_TX) begin
                if (!rspValid || rspReady) begin
                    if (rspValid && rspLast) begin
                        rspValid <= 1'b0;
                        rspLast <= 1'b0;
                    end else begin
                        rspValid <= 1'b1;
                        rspByte <= (rspIdx == 6'd0) ? (buf_reg[0] | status_reg)
                            : buf_reg[rspIdx];
                        rspLast <= (rspIdx == endIdx_reg);
                    end
                end
            end else begin
                rspValid <= 1'b0;
                rspLast <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // control sequencer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= S_IDLE;
            idx_reg <= 6'd0;
            endIdx_reg <= 6'd0;
            status_reg <= 8'h00;
            pinOut <= HPB_PIN_RESET;
            shLoad <= 1'b0;
            shByte <= 8'h00;
            shEn <= 1'b0;
            q_reg <= 2'd0;
            bit_reg <= 4'd0;
            tw_reg <= T_START;
            twSeg_reg <= 2'd0;
            restarted_reg <= 1'b0;
            sclOe <= 1'b0;
            sdaOe <= 1'b0;
            spiClk <= 1'b0;
            spiMosi <= 1'b0;
            spiCsN <= 1'b1;
        end else begin
            shLoad <= 1'b0;
            shEn <= 1'b0;
            case (state_reg)
                S_IDLE, S_RX: begin
                    if (rxTake) begin
                        buf_reg[rxCnt_reg] <= pktByte;
                        state_reg <= rxEnd ? S_DEC : S_RX;
                    end
                end
                S_DEC: begin
                    idx_reg <= 6'd0;
                    endIdx_reg <= 6'(HPB_HDR - 1) + 6'(lenB > 8'd60 ? 8'd60 : lenB);
                    restarted_reg <= 1'b0;
                    if (!validHdr(buf_reg[0])) begin
                        status_reg <= HPB_ST_REQERR;
                        state_reg <= S_TX;
                    end else if (ifCode == HPB_IF_PIN) begin
                        endIdx_reg <= 6'(HPB_HDR);
                        state_reg <= S_PIN;
                    end else if (ifCode == HPB_IF_STD || ifCode == HPB_IF_FAST) begin
                        status_reg <= HPB_ST_DONE;
                        tw_reg <= T_START;
                        twSeg_reg <= 2'd0;
                        q_reg <= 2'd0;
                        state_reg <= S_TW;
                    end else begin
                        status_reg <= HPB_ST_DONE;
                        idx_reg <= (ifCode == HPB_IF_SPI16) ? 6'd1 : 6'd3;
                        shLoad <= 1'b1;
                        shByte <= (ifCode == HPB_IF_SPI16) ? buf_reg[1] : buf_reg[3];
                        bit_reg <= 4'd0;
                        q_reg <= 2'd0;
                        spiCsN <= 1'b0;
                        state_reg <= S_SPI;
                    end
                end
                S_PIN: begin
                    if (isWrite) begin
                        pinOut <= buf_reg[4][6:0];
                    end else begin
                        buf_reg[4] <= {1'b0, pinIn};
                    end
                    status_reg <= HPB_ST_DONE;
                    state_reg <= S_TX;
                end
                S_SPI: begin
                    if (tick) begin
                        spiClk <= !spiClk;
                        if (!spiClk) begin
                            shEn <= 1'b1;
                        end else if (bit_reg == 4'd7) begin
                            bit_reg <= 4'd0;
                            q_reg <= 2'd1;
                        end else begin
                            bit_reg <= bit_reg + 4'd1;
                        end
                    end else if (q_reg == 2'd1) begin
                        q_reg <= 2'd0;
                        if (idx_reg < 6'd4 || !isWrite) begin
                            buf_reg[idx_reg] <= shCap;
                        end
                        if (idx_reg >= endIdx_reg) begin
                            spiCsN <= 1'b1;
                            spiMosi <= 1'b0;
                            state_reg <= S_TX;
                        end else begin
                            idx_reg <= (idx_reg == 6'd1) ? 6'd3 : idx_reg + 6'd1;
                            shLoad <= 1'b1;
                            shByte <= (idx_reg == 6'd1) ? buf_reg[3]
                                : (isWrite ? buf_reg[idx_reg + 6'd1] : 8'h00);
                        end
                    end else if (!spiClk) begin
                        // data settles while the clock is low
                        spiMosi <= shOut;
                    end
                end
                S_TW: begin
                    // hold while a target stretches the clock
                    if (tick && !(q_reg == 2'd2 && !sclIn)) begin
                        q_reg <= q_reg + 2'd1;
                        case (tw_reg)
                            T_START: begin
                                if (q_reg == 2'd0) begin
                                    sdaOe <= 1'b0;
                                end else if (q_reg == 2'd1) begin
                                    sclOe <= 1'b0;
                                end else if (q_reg == 2'd2) begin
                                    sdaOe <= 1'b1;
                                end else begin
                                    sclOe <= 1'b1;
                                    tw_reg <= T_BIT;
                                    bit_reg <= 4'd0;
                                    shLoad <= 1'b1;
                                    if (twSeg_reg == 2'd0 || restarted_reg) begin
                                        // r/w bit is a read only for a read operation after the restart
                                        shByte <= {buf_reg[1][7:1], twRead};
                                    end else begin
                                        shByte <= buf_reg[3];
                                    end
                                end
                            end
                            T_BIT: begin
                                if (q_reg == 2'd0) begin
                                    sdaOe <= twRead && twSeg_reg == 2'd2 ? 1'b0 : !shOut;
                                end else if (q_reg == 2'd1) begin
                                    sclOe <= 1'b0;
                                end else if (q_reg == 2'd2) begin
                                    shEn <= 1'b1;
                                end else begin
                                    sclOe <= 1'b1;
                                    if (bit_reg == 4'd7) begin
                                        tw_reg <= T_ACK;
                                    end
                                    bit_reg <= bit_reg + 4'd1;
                                end
                            end
                            T_ACK: begin
                                if (q_reg == 2'd0) begin
                                    // master acks all but the last read byte
                                    sdaOe <= twRead && twSeg_reg == 2'd2
                                        && idx_reg != endIdx_reg;
                                end else if (q_reg == 2'd1) begin
                                    sclOe <= 1'b0;
                                end else if (q_reg == 2'd2) begin
                                    if (!(twRead && twSeg_reg == 2'd2) && sdaIn) begin
                                        status_reg <= HPB_ST_FAULT;
                                        tw_reg <= T_STOP;
                                    end
                                end else begin
                                    sclOe <= 1'b1;
                                    if (tw_reg == T_ACK) begin
                                        tw_reg <= T_BIT;
                                        bit_reg <= 4'd0;
                                        shLoad <= 1'b1;
                                        if (twRead && twSeg_reg == 2'd2) begin
                                            buf_reg[idx_reg] <= shCap;
                                        end
                                        if (twSeg_reg == 2'd0) begin
                                            twSeg_reg <= restarted_reg ? 2'd2 : 2'd1;
                                            shByte <= restarted_reg ? 8'hFF : buf_reg[3];
                                            idx_reg <= 6'd4;
                                            if (endIdx_reg < 6'd4 && restarted_reg) begin
                                                tw_reg <= T_STOP;
                                            end
                                        end else if (twSeg_reg == 2'd1 && !isWrite) begin
                                            restarted_reg <= 1'b1;
                                            twSeg_reg <= 2'd0;
                                            tw_reg <= T_START;
                                        end else begin
                                            twSeg_reg <= 2'd2;
                                            if (twSeg_reg == 2'd2) begin
                                                idx_reg <= idx_reg + 6'd1;
                                            end
                                            if ((twSeg_reg == 2'd2 ? idx_reg : 6'd3)
                                                >= endIdx_reg) begin
                                                tw_reg <= T_STOP;
                                            end
                                            shByte <= isWrite ? buf_reg[twSeg_reg == 2'd2
                                                ? idx_reg + 6'd1 : 6'd4] : 8'hFF;
                                        end
                                    end
                                end
                            end
                            T_STOP: begin
                                if (q_reg == 2'd0) begin
                                    sdaOe <= 1'b1;
                                end else if (q_reg == 2'd1) begin
                                    sclOe <= 1'b0;
                                end else if (q_reg == 2'd2) begin
                                    sdaOe <= 1'b0;
                                end else begin
                                    state_reg <= S_TX;
                                end
                            end
                            default: tw_reg <= T_START;
                        endcase
                    end
                end
                S_TX: begin
                    if (rspValid && rspReady) begin
                        if (rspLast) begin
                            state_reg <= S_IDLE;
                            idx_reg <= 6'd0;
                        end else begin
                            idx_reg <= idx_reg + 6'd1;
                        end
                    end else if (!rspValid) begin
                        idx_reg <= 6'd0;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end
endmodule

// ### logic/hpb_pkg.sv
// constants for the host packet serial bus bridge
package hpb_pkg;
    localparam logic [7:0] HPB_OP_READ = 8'h00;
    localparam logic [7:0] HPB_OP_WRITE = 8'h10;
    localparam logic [7:0] HPB_IF_PIN = 8'h08;
    localparam logic [7:0] HPB_IF_SPI16 = 8'h04;
    localparam logic [7:0] HPB_IF_FAST = 8'h02;
    localparam logic [7:0] HPB_IF_STD = 8'h01;
    localparam logic [7:0] HPB_IF_SPI8 = 8'h00;
    localparam logic [7:0] HPB_ST_REQERR = 8'h80;
    localparam logic [7:0] HPB_ST_FAULT = 8'h40;
    localparam logic [7:0] HPB_ST_DONE = 8'h20;
    localparam int HPB_MAX_PKT = 64;
    localparam int HPB_HDR = 4;
    localparam int HPB_CLK_HZ = 100_000_000;
    localparam int HPB_STD_HZ = 100_000;
    localparam int HPB_FAST_HZ = 400_000;
    localparam int HPB_SPI_HZ = 1_000_000;
    // two-wire quarter-period and spi half-period counts, each rounded toward slower (up)
    localparam int HPB_STD_Q = (HPB_CLK_HZ + 4 * HPB_STD_HZ - 1) / (4 * HPB_STD_HZ);
    localparam int HPB_FAST_Q = (HPB_CLK_HZ + 4 * HPB_FAST_HZ - 1) / (4 * HPB_FAST_HZ);
    localparam int HPB_SPI_H = (HPB_CLK_HZ + 2 * HPB_SPI_HZ - 1) / (2 * HPB_SPI_HZ);
    localparam logic [6:0] HPB_PIN_RESET = 7'h00;
endpackage

// ### logic/hpb_shift.sv
// byte shifter for spi and two-wire bit phases
`timescale 1ns/10ps
module hpb_shift
    import hpb_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [7:0] loadByte,
    input wire logic shiftEn,
    input wire logic inBit,
    output logic outBit,
    output logic [7:0] capByte
);
    logic [7:0] sh_reg;
    assign outBit = sh_reg[7];
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sh_reg <= 8'h00;
            capByte <= 8'h00;
        end else if (load) begin
            sh_reg <= loadByte;
        end else if (shiftEn) begin
            sh_reg <= {sh_reg[6:0], 1'b0};
            capByte <= {capByte[6:0], inBit};
        end
    end
endmodule

// ### logic/hpb_tick.sv
// divider making one-cycle enable pulses
`timescale 1ns/10ps
module hpb_tick
    import hpb_pkg::*;
#(
    parameter int W = 12
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [W-1:0] period,
    output logic tick
);
    logic [W-1:0] cnt_reg;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            tick <= 1'b0;
        end else if (!run) begin
            cnt_reg <= '0;
            tick <= 1'b0;
        end else if (cnt_reg + 1'b1 >= period) begin
            cnt_reg <= '0;
            tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule

// ### tb/hpb_bridge_props.sv
// port checker for the packet bridge
`timescale 1ns/10ps
module hpb_bridge_props
    import hpb_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic pktValid,
    input wire logic pktLast,
    input wire logic pktReady,
    input wire logic rspValid,
    input wire logic [7:0] rspByte,
    input wire logic rspLast,
    input wire logic rspReady,
    input wire logic sclOe,
    input wire logic sdaOe,
    input wire logic spiClk,
    input wire logic spiCsN,
    input wire logic [6:0] pinOut,
    input wire logic busy
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence sPktEnd; pktValid && pktReady && pktLast; endsequence
    sequence sRspEnd; rspValid && rspReady && rspLast; endsequence
    AST_BUSY_REFUSE: assert property (busy |-> !pktReady)
        else $error("ready while busy");
    AST_EXEC_START: assert property (sPktEnd |-> ##[1:3] busy)
        else $error("no busy after packet");
    AST_RSP_HOLD: assert property (rspValid && !rspReady |=>
        rspValid && $stable(rspByte) && $stable(rspLast)) else $error("rsp not held");
    AST_RSP_END: assert property (sRspEnd |=> !rspValid)
        else $error("rsp past last");
    AST_RSP_BUSY: assert property (rspValid |-> busy)
        else $error("rsp while idle");
    AST_RSP_BUS_FREE: assert property (rspValid |-> spiCsN && !sclOe && !sdaOe)
        else $error("rsp before bus free");
    AST_SPI_IDLE: assert property (spiCsN |-> !spiClk)
        else $error("spi clock without select");
    AST_PIN_HOLD: assert property (!busy |=> $stable(pinOut))
        else $error("pins moved while idle");
    AST_READY_BACK: assert property (sRspEnd |=> ##[0:3] pktReady)
        else $error("not ready after rsp");
endmodule

bind hpb_bridge hpb_bridge_props u_props (.ref_clk(ref_clk), .rst_n(rst_n),
    .pktValid(pktValid), .pktLast(pktLast), .pktReady(pktReady), .rspValid(rspValid),
    .rspByte(rspByte), .rspLast(rspLast), .rspReady(rspReady), .sclOe(sclOe), .sdaOe(sdaOe),
    .spiClk(spiClk), .spiCsN(spiCsN), .pinOut(pinOut), .busy(busy));

// ### tb/hpb_bus_model.sv
// far-side model: two-wire target, spi target, pin loop
`timescale 1ns/10ps
module hpb_bus_model
    import hpb_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sclOe,
    input wire logic sdaOe,
    input wire logic spiClk,
    input wire logic spiCsN,
    input wire logic spiMosi,
    input wire logic [6:0] pinOut,
    input wire logic nak,
    input wire logic [6:0] pinFlip,
    output logic sclIn,
    output logic sdaIn,
    output logic spiMiso,
    output logic [6:0] pinIn,
    output logic [7:0] mosiByte
);
    logic ackReg = 1'b0, togReg = 1'b0;
    logic [3:0] bitCnt = 4'hF;
    logic [7:0] spiCnt = 8'h00, spiPat;
    // lines pulled up when released
    assign sclIn = !sclOe;
    assign sdaIn = !(sdaOe || ackReg);
    always @(negedge sdaIn) if (sclIn) bitCnt = 4'hF;
    always @(negedge sclIn) begin
        bitCnt = (bitCnt == 4'h8) ? 4'h0 : bitCnt + 4'h1;
        ackReg = (bitCnt == 4'h8) && !nak;
    end
    always @(negedge spiCsN) spiCnt = 8'h00;
    always @(posedge spiClk) if (!spiCsN) mosiByte = {mosiByte[6:0], spiMosi};
    always @(negedge spiClk) if (!spiCsN) spiCnt = spiCnt + 8'h01;
    always @(posedge ref_clk) togReg <= !togReg;
    assign spiPat = {4'hA, spiCnt[6:3]};
    assign spiMiso = spiCsN ? togReg : spiPat[3'h7 - spiCnt[2:0]];
    assign pinIn = pinOut ^ pinFlip;
endmodule

// ### tb/tb_hpb_bridge.sv
// self-checking bench for the packet bridge
`timescale 1ns/10ps
`define HPB_CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module tb_hpb_bridge
    import hpb_pkg::*;
;
    logic ref_clk = 1'b0, rst_n = 1'b0, pktValid = 1'b0, pktLast = 1'b0, rspReady = 1'b0;
    logic nak = 1'b0, pktReady, rspValid, rspLast, sclOe, sdaOe, sclIn, sdaIn, busy;
    logic spiClk, spiMosi, spiMiso, spiCsN;
    logic [7:0] mosiByte;
    logic [7:0] pktByte = 8'h00, pv = 8'h00, rspByte;
    logic [7:0] badOp[4] = '{8'h13, 8'h05, 8'h0C, 8'h30};
    logic [6:0] pinFlip = 7'h00, pinOut, pinIn;
    logic [8:0] expQ[$];
    logic [8:0] expv;
    int err_total = 0, n_checks = 0;
    integer seed = 32'hb898af19;
    hpb_bridge u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .pktValid(pktValid),
        .pktByte(pktByte), .pktLast(pktLast), .pktReady(pktReady), .rspValid(rspValid),
        .rspByte(rspByte), .rspLast(rspLast), .rspReady(rspReady), .sclOe(sclOe),
        .sclIn(sclIn), .sdaOe(sdaOe), .sdaIn(sdaIn), .spiClk(spiClk), .spiMosi(spiMosi),
        .spiMiso(spiMiso), .spiCsN(spiCsN), .pinOut(pinOut), .pinIn(pinIn), .busy(busy));
    hpb_bus_model u_far (.ref_clk(ref_clk), .sclOe(sclOe), .sdaOe(sdaOe), .spiClk(spiClk),
        .spiCsN(spiCsN), .spiMosi(spiMosi), .pinOut(pinOut), .nak(nak), .pinFlip(pinFlip),
        .sclIn(sclIn), .sdaIn(sdaIn), .spiMiso(spiMiso), .pinIn(pinIn), .mosiByte(mosiByte));
    initial forever #5 ref_clk = !ref_clk;
    always @(posedge ref_clk) rspReady <= #1 ($random(seed) % 4) != 0;
    always @(posedge ref_clk) begin
        if (rst_n && rspValid === 1'b1 && rspReady) begin
            `HPB_CHK(expQ.size() != 0, 1'b1)
            expv = (expQ.size() != 0) ? expQ.pop_front() : 9'h100;
            if (!expv[8]) `HPB_CHK(rspByte, expv[7:0])
            `HPB_CHK(rspLast, expQ.size() == 0)
        end
    end
    task automatic summarize();
        if (err_total == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic bound(input int k, input int lim);
        `HPB_CHK(k < lim, 1'b1)
        if (k >= lim) summarize();
    endtask
    task automatic run(input logic [7:0] req[$], input logic [8:0] rsp[$]);
        int k;
        foreach (rsp[i]) expQ.push_back(rsp[i]);
        foreach (req[i]) begin
            pktValid = 1'b1;
            pktByte = req[i];
            pktLast = (i == req.size() - 1);
            @(posedge ref_clk);
            for (k = 0; pktReady !== 1'b1 && k < 100; k++) @(posedge ref_clk);
            bound(k, 100);
            #1;
        end
        pktValid = 1'b0;
        pktLast = 1'b0;
        for (k = 0; expQ.size() != 0 && k < 60000; k++) @(posedge ref_clk);
        bound(k, 60000);
        #1;
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        `HPB_CHK(pinOut, HPB_PIN_RESET)
        pv = $random(seed);
        run('{8'h18, 8'h5C, 8'h01, 8'h7E, pv},
            '{9'h038, 9'h100, 9'h001, 9'h100, {1'b0, pv}});
        `HPB_CHK(pinOut, pv[6:0])
        pinFlip = $random(seed);
        run('{8'h08, 8'h00, 8'h01, 8'h00},
            '{9'h028, 9'h100, 9'h001, 9'h100, {2'b00, pv[6:0] ^ pinFlip}});
        foreach (badOp[i]) run('{badOp[i], 8'hA0, 8'h02, 8'h05, 8'hAA, 8'h55},
            '{{1'b0, badOp[i] | HPB_ST_REQERR}, 9'h0A0, 9'h002, 9'h005, 9'h0AA, 9'h055});
        `HPB_CHK(pinOut, pv[6:0])
        run('{8'h12, 8'hA0, 8'h02, 8'h05, 8'hAA, 8'h55},
            '{9'h032, 9'h0A0, 9'h002, 9'h005, 9'h0AA, 9'h055});
        run('{8'h02, 8'hA0, 8'h01, 8'h05}, '{9'h022, 9'h0A0, 9'h001, 9'h005, 9'h0FF});
        nak = 1'b1;
        run('{8'h11, 8'hA0, 8'h01, 8'h05, 8'h3C},
            '{9'h051, 9'h0A0, 9'h001, 9'h005, 9'h03C});
        nak = 1'b0;
        run('{8'h14, 8'h10, 8'h02, 8'hE0, 8'hAA, 8'h55},
            '{9'h034, 9'h0A0, 9'h002, 9'h0A1, 9'h0AA, 9'h055});
        `HPB_CHK(mosiByte, 8'h55)
        run('{8'h04, 8'h10, 8'h02, 8'hE0},
            '{9'h024, 9'h0A0, 9'h002, 9'h0A1, 9'h0A2, 9'h0A3});
        `HPB_CHK(mosiByte, 8'h00)
        run('{8'h10, 8'h77, 8'h01, 8'h05, 8'hC3}, '{9'h030, 9'h100, 9'h001, 9'h0A0, 9'h0C3});
        `HPB_CHK(mosiByte, 8'hC3)
        run('{8'h00, 8'h77, 8'h01, 8'h05}, '{9'h020, 9'h100, 9'h001, 9'h0A0, 9'h0A1});
        `HPB_CHK(mosiByte, 8'h00)
        summarize();
    end
endmodule
